// ===== logic/pov_pkg.sv
// Constants, encodings and timing for the overvoltage and input threshold registers.
// Functional notes
// - The loop scaling register keeps a writable signed exponent in bits 15:11, reads bit 10 as zero and keeps a writable 10-bit mantissa in bits 9:0.
// - The monitor scaling register reads bits 15:14 and bit 10 as zero and keeps a writable exponent in bits 13:11 and mantissa in bits 9:0.
// - Conversion starts once the measured input voltage reaches the turn-on threshold.
// - Conversion stops once the measured input voltage falls to the turn-off threshold.
// - Both input thresholds read their exponent in bits 15:11 from the external input exponent, and writes there are ignored.
// - Both input thresholds keep a writable 11-bit mantissa in bits 10:0, scaled by two to the input exponent.
// - An output overvoltage fault is raised while the output voltage is above the programmed limit.
// - The overvoltage limit reads its exponent in bits 15:11 from the signed output voltage exponent.
// - The overvoltage limit keeps a writable 11-bit mantissa in bits 10:0, scaled by two to the output exponent.
// - Bits 7:6 of the fault response register are writable and pick the reaction to an overvoltage fault.
// - One reaction rides through for delay time 1 and then, if the fault persists, shuts down and retries as often as bits 5:3 allow.
// - Code 10 shuts the output down at once and then retries as often as bits 5:3 allow.
// - Code 11 turns the output off while the fault remains and turns it on again when it clears.
// - Retry codes 0 to 6 allow that many restarts, 7 allows endless restarts, and after the last one the output stays off until reset.
// - Bits 2:0 pick delay time 1 and the restart interval, 10/252 ms, 20/558 ms or 40/924 ms.
package pov_pkg;

  // Command codes of the registers.
  localparam logic [7:0] CMD_LOOP_SCALE = 8'h29;
  localparam logic [7:0] CMD_MON_SCALE  = 8'h2A;
  localparam logic [7:0] CMD_INPUT_TURN_ON_THRESHOLD     = 8'h35;
  localparam logic [7:0] CMD_INPUT_TURN_OFF_THRESHOLD    = 8'h36;
  localparam logic [7:0] CMD_OV_LIMIT   = 8'h40;
  localparam logic [7:0] CMD_OV_RESP    = 8'h41;

  // Writable bit masks of the scaling registers.
  localparam logic [15:0] LOOP_WR_MASK = 16'hFBFF;
  localparam logic [15:0] MON_WR_MASK  = 16'h3BFF;

  // Field positions.
  localparam int EXP_LSB       = 11;
  localparam int MANT_MSB      = 10;
  localparam int RESP_MODE_LSB = 6;
  localparam int RETRY_LSB     = 3;
  localparam int DELAY_LSB     = 0;

  // Values after reset.
  localparam logic [15:0] RST_LOOP_SCALE = 16'h0000;
  localparam logic [15:0] RST_MON_SCALE  = 16'h0000;
  localparam logic [10:0] RST_INPUT_TURN_ON_THRESHOLD     = 11'h000;
  localparam logic [10:0] RST_INPUT_TURN_OFF_THRESHOLD    = 11'h000;
  localparam logic [10:0] RST_OV_LIMIT   = 11'h7FF;
  localparam logic [7:0]  RST_OV_RESP    = 8'h80;

  // Retry code meaning endless restarts.
  localparam logic [2:0] RETRY_ENDLESS = 3'h7;

  // Delay times in milliseconds and the clock rate in kilohertz.
  localparam int CLK_KHZ   = 125000;
  localparam int DLY1_0_MS = 10;
  localparam int DLY1_1_MS = 20;
  localparam int DLY1_2_MS = 40;
  localparam int DLY2_0_MS = 252;
  localparam int DLY2_1_MS = 558;
  localparam int DLY2_2_MS = 924;
  localparam int DLY1_0_CYC = DLY1_0_MS * CLK_KHZ;
  localparam int DLY1_1_CYC = DLY1_1_MS * CLK_KHZ;
  localparam int DLY1_2_CYC = DLY1_2_MS * CLK_KHZ;
  localparam int DLY2_0_CYC = DLY2_0_MS * CLK_KHZ;
  localparam int DLY2_1_CYC = DLY2_1_MS * CLK_KHZ;
  localparam int DLY2_2_CYC = DLY2_2_MS * CLK_KHZ;

  // Reaction to an output overvoltage fault.
  typedef enum logic [1:0] {
    POV_RESP_IGNORE   = 2'h0,
    POV_RESP_RIDE     = 2'h1,
    POV_RESP_SHUTDOWN = 2'h2,
    POV_RESP_HOLD     = 2'h3
  } pov_resp_t;

  // Fault handling states.
  typedef enum logic [4:0] {
    POV_ST_RUN     = 5'h01,
    POV_ST_RIDE    = 5'h02,
    POV_ST_RESTART = 5'h04,
    POV_ST_HOLD    = 5'h08,
    POV_ST_LOCKOUT = 5'h10
  } pov_state_t;

endpackage : pov_pkg

// ===== logic/pov_lin_scale.sv
// Converts a linear-format mantissa and signed exponent to fixed point.
`timescale 1ns/1ps
module pov_lin_scale #(
  parameter int MANT_W = 11,
  parameter int OUT_W  = 24,
  parameter int FRAC   = 8
) (
  // Linear-format operand
  input  logic [MANT_W-1:0] mant,
  input  logic [2:0]        exp_code,
  // Fixed-point result with FRAC fraction bits
  output logic [OUT_W-1:0]  scaled
);

  logic [OUT_W+MANT_W-1:0] wide;
  int                      shift;

  // Shifts the mantissa by the exponent plus the fraction width.
  always_comb begin
    shift = FRAC + int'($signed(exp_code));
    wide  = {{OUT_W{1'b0}}, mant};
    if (shift >= 0) begin
      wide = wide << shift;
    end else begin
      wide = wide >> (-shift);
    end
    scaled = wide[OUT_W-1:0];
  end

endmodule : pov_lin_scale

// ===== logic/pov_delay_timer.sv
// Down-counting delay timer with a one-cycle done pulse.
`timescale 1ns/1ps
module pov_delay_timer #(
  parameter int CNT_W = 32
) (
  // Clock and reset
  input  logic             clk,
  input  logic             rst_n,
  // Control
  input  logic             start,
  input  logic [CNT_W-1:0] count,
  // Expiry
  output logic             done
);

  logic [CNT_W-1:0] cnt_ff;
  logic             done_ff;

  // Loads on start and counts down to zero; a start cancels old runs.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= count;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // Pulses when the last count is spent, never in the cycle after a start.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= !start && (cnt_ff == {{(CNT_W-1){1'b0}}, 1'b1});
    end
  end

  assign done = done_ff;

endmodule : pov_delay_timer

// ===== logic/pov_ov_config.sv
// Threshold, scaling and overvoltage response registers with fault handling.
`timescale 1ns/1ps
module pov_ov_config #(
  parameter int MEAS_W   = 24,
  parameter int FRAC     = 8,
  parameter int DLY1_0   = pov_pkg::DLY1_0_CYC,
  parameter int DLY1_1   = pov_pkg::DLY1_1_CYC,
  parameter int DLY1_2   = pov_pkg::DLY1_2_CYC,
  parameter int DLY2_0   = pov_pkg::DLY2_0_CYC,
  parameter int DLY2_1   = pov_pkg::DLY2_1_CYC,
  parameter int DLY2_2   = pov_pkg::DLY2_2_CYC
) (
  // Clock and reset
  input  logic              sys_clk,
  input  logic              rst_n,
  // Command port from the bus front end
  input  logic [7:0]        cmd_code,
  input  logic              cmd_wr_stb,
  input  logic [15:0]       cmd_wr_data,
  input  logic              cmd_rd_stb,
  output logic [15:0]       rd_data_ff,
  output logic              rd_valid_ff,
  output logic              cmd_nack_ff,
  // Exponents held elsewhere
  input  logic [2:0]        vin_exponent,
  input  logic [2:0]        vout_exponent,
  // Measured voltages, fixed point
  input  logic [MEAS_W-1:0] vin_meas,
  input  logic [MEAS_W-1:0] vout_meas,
  // Scaling factors to the datapath
  output logic [15:0]       loop_scale_ff,
  output logic [15:0]       monitor_scale_ff,
  // Power state
  output logic              conv_enable_ff,
  output logic              out_enable_ff,
  output logic              ov_fault_ff,
  output logic              ov_lockout_ff
);

  logic [1:0]          rst_sync_ff;
  logic                rst_n_sys;
  logic [10:0]         input_turn_on_threshold_mant_ff;
  logic [10:0]         input_turn_off_threshold_mant_ff;
  logic [10:0]         ov_mant_ff;
  logic [7:0]          ov_resp_ff;
  logic [MEAS_W-1:0]   input_turn_on_threshold_thr;
  logic [MEAS_W-1:0]   input_turn_off_threshold_thr;
  logic [MEAS_W-1:0]   ov_thr;
  pov_pkg::pov_state_t state_ff;
  pov_pkg::pov_resp_t  resp_mode;
  logic [2:0]          retry_code;
  logic [2:0]          delay_code;
  logic [2:0]          retry_cnt_ff;
  logic                retry_ok;
  logic                fault_trip;
  logic                tmr_start_ff;
  logic [31:0]         tmr_count_ff;
  logic                tmr_done;

  // Sign-extends a three-bit exponent to the five-bit field.
  function automatic logic [4:0] sext_exp(input logic [2:0] e);
    sext_exp = {{2{e[2]}}, e};
  endfunction : sext_exp

  // Tells whether a command code names one of these registers.
  function automatic logic is_mapped(input logic [7:0] c);
    is_mapped = (c == pov_pkg::CMD_LOOP_SCALE) ||
                (c == pov_pkg::CMD_MON_SCALE)  ||
                (c == pov_pkg::CMD_INPUT_TURN_ON_THRESHOLD)     ||
                (c == pov_pkg::CMD_INPUT_TURN_OFF_THRESHOLD)    ||
                (c == pov_pkg::CMD_OV_LIMIT)   ||
                (c == pov_pkg::CMD_OV_RESP);
  endfunction : is_mapped

  // Ride-through time per delay code; unlisted codes use the longest.
  function automatic logic [31:0] dly1_cycles(input logic [2:0] d);
    case (d)
      3'h0:    dly1_cycles = 32'(DLY1_0);
      3'h1:    dly1_cycles = 32'(DLY1_1);
      default: dly1_cycles = 32'(DLY1_2);
    endcase
  endfunction : dly1_cycles

  // Restart interval per delay code; unlisted codes use the longest.
  function automatic logic [31:0] dly2_cycles(input logic [2:0] d);
    case (d)
      3'h0:    dly2_cycles = 32'(DLY2_0);
      3'h1:    dly2_cycles = 32'(DLY2_1);
      default: dly2_cycles = 32'(DLY2_2);
    endcase
  endfunction : dly2_cycles

  // Releases the external reset through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n_sys = rst_sync_ff[1];

  // Stores writes; read-only and reserved bits are dropped on the way in.
  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      loop_scale_ff    <= pov_pkg::RST_LOOP_SCALE;
      monitor_scale_ff <= pov_pkg::RST_MON_SCALE;
      input_turn_on_threshold_mant_ff   <= pov_pkg::RST_INPUT_TURN_ON_THRESHOLD;
      input_turn_off_threshold_mant_ff  <= pov_pkg::RST_INPUT_TURN_OFF_THRESHOLD;
      ov_mant_ff       <= pov_pkg::RST_OV_LIMIT;
      ov_resp_ff       <= pov_pkg::RST_OV_RESP;
    end else if (cmd_wr_stb) begin
      case (cmd_code)
        pov_pkg::CMD_LOOP_SCALE: begin
          loop_scale_ff <= cmd_wr_data & pov_pkg::LOOP_WR_MASK;
        end
        pov_pkg::CMD_MON_SCALE: begin
          monitor_scale_ff <= cmd_wr_data & pov_pkg::MON_WR_MASK;
        end
        pov_pkg::CMD_INPUT_TURN_ON_THRESHOLD: begin
          input_turn_on_threshold_mant_ff <= cmd_wr_data[pov_pkg::MANT_MSB:0];
        end
        pov_pkg::CMD_INPUT_TURN_OFF_THRESHOLD: begin
          input_turn_off_threshold_mant_ff <= cmd_wr_data[pov_pkg::MANT_MSB:0];
        end
        pov_pkg::CMD_OV_LIMIT: begin
          ov_mant_ff <= cmd_wr_data[pov_pkg::MANT_MSB:0];
        end
        pov_pkg::CMD_OV_RESP: begin
          ov_resp_ff <= cmd_wr_data[7:0];
        end
        default: begin
          ov_resp_ff <= ov_resp_ff;
        end
      endcase
    end
  end

  // Answers a read one cycle after the strobe.
  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      rd_data_ff  <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= cmd_rd_stb;
      if (cmd_rd_stb) begin
        case (cmd_code)
          pov_pkg::CMD_LOOP_SCALE: rd_data_ff <= loop_scale_ff;
          pov_pkg::CMD_MON_SCALE:  rd_data_ff <= monitor_scale_ff;
          pov_pkg::CMD_INPUT_TURN_ON_THRESHOLD: begin
            rd_data_ff <= {sext_exp(vin_exponent), input_turn_on_threshold_mant_ff};
          end
          pov_pkg::CMD_INPUT_TURN_OFF_THRESHOLD: begin
            rd_data_ff <= {sext_exp(vin_exponent), input_turn_off_threshold_mant_ff};
          end
          pov_pkg::CMD_OV_LIMIT: begin
            rd_data_ff <= {sext_exp(vout_exponent), ov_mant_ff};
          end
          pov_pkg::CMD_OV_RESP: rd_data_ff <= {8'h00, ov_resp_ff};
          default:              rd_data_ff <= 16'h0000;
        endcase
      end
    end
  end

  // Flags an access to a code that these registers do not answer.
  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      cmd_nack_ff <= 1'b0;
    end else begin
      cmd_nack_ff <= (cmd_rd_stb || cmd_wr_stb) && !is_mapped(cmd_code);
    end
  end

  // Thresholds in the fixed-point format of the measurements.
  pov_lin_scale #(.MANT_W(11), .OUT_W(MEAS_W), .FRAC(FRAC)) u_input_turn_on_threshold (
    .mant     (input_turn_on_threshold_mant_ff),
    .exp_code (vin_exponent),
    .scaled   (input_turn_on_threshold_thr)
  );

  pov_lin_scale #(.MANT_W(11), .OUT_W(MEAS_W), .FRAC(FRAC)) u_input_turn_off_threshold (
    .mant     (input_turn_off_threshold_mant_ff),
    .exp_code (vin_exponent),
    .scaled   (input_turn_off_threshold_thr)
  );

  pov_lin_scale #(.MANT_W(11), .OUT_W(MEAS_W), .FRAC(FRAC)) u_ov_lim (
    .mant     (ov_mant_ff),
    .exp_code (vout_exponent),
    .scaled   (ov_thr)
  );

  // Input hysteresis: the on and off levels give two separate edges.
  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      conv_enable_ff <= 1'b0;
    end else if (!conv_enable_ff && (vin_meas >= input_turn_on_threshold_thr)) begin
      conv_enable_ff <= 1'b1;
    end else if (conv_enable_ff && (vin_meas <= input_turn_off_threshold_thr)) begin
      conv_enable_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      ov_fault_ff <= 1'b0;
    end else begin
      ov_fault_ff <= (vout_meas > ov_thr);
    end
  end

  assign resp_mode  = pov_pkg::pov_resp_t'(
                        ov_resp_ff[pov_pkg::RESP_MODE_LSB +: 2]);
  assign retry_code = ov_resp_ff[pov_pkg::RETRY_LSB +: 3];
  assign delay_code = ov_resp_ff[pov_pkg::DELAY_LSB +: 3];

  assign retry_ok = (retry_code == pov_pkg::RETRY_ENDLESS) ||
                    (retry_cnt_ff < retry_code);

  // immediate shutdown, and ride-through that ran out.
  assign fault_trip =
    ((state_ff == pov_pkg::POV_ST_RUN) && ov_fault_ff &&
     (resp_mode == pov_pkg::POV_RESP_SHUTDOWN)) ||
    ((state_ff == pov_pkg::POV_ST_RIDE) && ov_fault_ff && tmr_done);

  pov_delay_timer #(.CNT_W(32)) u_timer (
    .clk   (sys_clk),
    .rst_n (rst_n_sys),
    .start (tmr_start_ff),
    .count (tmr_count_ff),
    .done  (tmr_done)
  );

  // Fault reaction sequencer; the output stays off in the restart, hold and lockout states and stays on during ride-through.
  always_ff @(posedge sys_clk or negedge rst_n_sys) begin
    if (!rst_n_sys) begin
      state_ff      <= pov_pkg::POV_ST_RUN;
      out_enable_ff <= 1'b1;
      retry_cnt_ff  <= 3'h0;
      tmr_start_ff  <= 1'b0;
      tmr_count_ff  <= 32'h0000_0001;
      ov_lockout_ff <= 1'b0;
    end else begin
      tmr_start_ff <= 1'b0;
      if (fault_trip) begin
        out_enable_ff <= 1'b0;
        if (retry_ok) begin
          state_ff     <= pov_pkg::POV_ST_RESTART;
          tmr_start_ff <= 1'b1;
          tmr_count_ff <= dly2_cycles(delay_code);
          if (retry_code != pov_pkg::RETRY_ENDLESS) begin
            retry_cnt_ff <= retry_cnt_ff + 3'h1;
          end
        end else begin
          state_ff      <= pov_pkg::POV_ST_LOCKOUT;
          ov_lockout_ff <= 1'b1;
        end
      end else begin
        case (state_ff)
          pov_pkg::POV_ST_RUN: begin
            if (ov_fault_ff) begin
              case (resp_mode)
                pov_pkg::POV_RESP_RIDE: begin
                  state_ff     <= pov_pkg::POV_ST_RIDE;
                  tmr_start_ff <= 1'b1;
                  tmr_count_ff <= dly1_cycles(delay_code);
                end
                // switch off while the fault lasts.
                pov_pkg::POV_RESP_HOLD: begin
                  state_ff      <= pov_pkg::POV_ST_HOLD;
                  out_enable_ff <= 1'b0;
                end
                default: begin
                  state_ff <= pov_pkg::POV_ST_RUN;
                end
              endcase
            end else begin
              retry_cnt_ff <= 3'h0;
            end
          end
          pov_pkg::POV_ST_RIDE: begin
            if (!ov_fault_ff) begin
              state_ff <= pov_pkg::POV_ST_RUN;
            end
          end
          pov_pkg::POV_ST_RESTART: begin
            if (tmr_done) begin
              state_ff      <= pov_pkg::POV_ST_RUN;
              out_enable_ff <= 1'b1;
            end
          end
          pov_pkg::POV_ST_HOLD: begin
            if (!ov_fault_ff) begin
              state_ff      <= pov_pkg::POV_ST_RUN;
              out_enable_ff <= 1'b1;
            end
          end
          pov_pkg::POV_ST_LOCKOUT: begin
            out_enable_ff <= 1'b0;
          end
          default: begin
            state_ff      <= pov_pkg::POV_ST_RUN;
            out_enable_ff <= 1'b0;
          end
        endcase
      end
    end
  end

  // Checks on the register map and the fault sequencer.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_sys);

  chk_loop_write: assert property (
    cmd_wr_stb && (cmd_code == pov_pkg::CMD_LOOP_SCALE) |=>
    loop_scale_ff == ($past(cmd_wr_data) & 16'hFBFF))
    else $error("loop scale write stored wrong bits");

  chk_mon_write: assert property (
    cmd_wr_stb && (cmd_code == pov_pkg::CMD_MON_SCALE) |=>
    monitor_scale_ff == ($past(cmd_wr_data) & 16'h3BFF))
    else $error("monitor scale write stored wrong bits");

  chk_vin_start: assert property (
    !conv_enable_ff && (vin_meas >= input_turn_on_threshold_thr) |=> conv_enable_ff)
    else $error("conversion did not start at turn-on level");

  chk_vin_stop: assert property (
    conv_enable_ff && (vin_meas <= input_turn_off_threshold_thr) |=> !conv_enable_ff)
    else $error("conversion did not stop at turn-off level");

  chk_vin_exp: assert property (
    cmd_rd_stb && (cmd_code == pov_pkg::CMD_INPUT_TURN_OFF_THRESHOLD) |=>
    rd_valid_ff && (rd_data_ff[15:11] ==
      {{2{$past(vin_exponent[2])}}, $past(vin_exponent)}))
    else $error("input threshold exponent readback wrong");

  chk_ov_detect: assert property (
    (vout_meas > ov_thr) |=> ov_fault_ff)
    else $error("overvoltage not flagged");

  chk_ov_exp: assert property (
    cmd_rd_stb && (cmd_code == pov_pkg::CMD_OV_LIMIT) |=>
    rd_data_ff[15:11] == {{2{$past(vout_exponent[2])}},
                          $past(vout_exponent)})
    else $error("overvoltage limit exponent readback wrong");

  chk_shutdown_now: assert property (
    (state_ff == pov_pkg::POV_ST_RUN) && ov_fault_ff &&
    (resp_mode == pov_pkg::POV_RESP_SHUTDOWN) |=> !out_enable_ff)
    else $error("shutdown reaction left output on");

  chk_hold_off: assert property (
    (state_ff == pov_pkg::POV_ST_HOLD) && ov_fault_ff |=>
    !out_enable_ff ##1 !out_enable_ff || !$past(ov_fault_ff))
    else $error("hold reaction turned output on during fault");

  chk_ignore_run: assert property (
    (state_ff == pov_pkg::POV_ST_RUN) && out_enable_ff &&
    (resp_mode == pov_pkg::POV_RESP_IGNORE) |=> out_enable_ff)
    else $error("ignore reaction changed output");

  chk_lockout_stay: assert property (
    (state_ff == pov_pkg::POV_ST_LOCKOUT) |=>
    (state_ff == pov_pkg::POV_ST_LOCKOUT) && !out_enable_ff)
    else $error("lockout left before reset");

  cov_restart: cover property (
    (state_ff == pov_pkg::POV_ST_RESTART) ##1
    (state_ff == pov_pkg::POV_ST_RUN));
  cov_lockout: cover property (state_ff == pov_pkg::POV_ST_LOCKOUT);
  cov_hold_clear: cover property (
    (state_ff == pov_pkg::POV_ST_HOLD) ##1
    (state_ff == pov_pkg::POV_ST_RUN));
  cov_ride_clear: cover property (
    (state_ff == pov_pkg::POV_ST_RIDE) ##1
    (state_ff == pov_pkg::POV_ST_RUN));

endmodule : pov_ov_config

// ===== verification/pov_host_model.sv
// Host model that issues one command strobe at a time.
`timescale 1ns/1ps
module pov_host_model (
  // Clock
  input  logic        sys_clk,
  // Command side
  output logic [7:0]  cmd_code,
  output logic        cmd_wr_stb,
  output logic        cmd_rd_stb,
  output logic [15:0] cmd_wr_data,
  // Answer side
  input  logic [15:0] rd_data_ff,
  input  logic        rd_valid_ff,
  input  logic        cmd_nack_ff
);
  // Quiet port from time zero.
  initial begin
    cmd_code = 8'h0;
    cmd_wr_stb = 1'b0;
    cmd_rd_stb = 1'b0;
    cmd_wr_data = 16'h0;
  end

  // Strobe for one edge, collect the answer while it stands, then go idle.
  task automatic xfer(input logic [7:0] c, input logic [15:0] d,
    input logic w, output logic [17:0] r);
    @(negedge sys_clk);
    cmd_code = c;
    cmd_wr_data = d;
    cmd_wr_stb = w;
    cmd_rd_stb = !w;
    @(negedge sys_clk);
    r = {rd_valid_ff, cmd_nack_ff, rd_data_ff};
    cmd_wr_stb = 1'b0;
    cmd_rd_stb = 1'b0;
    cmd_code = ~c;
    cmd_wr_data = ~d;
  endtask : xfer
endmodule : pov_host_model

// ===== verification/pov_ov_config_bench.sv
// Self-checking bench for the overvoltage and threshold register block.
`timescale 1ns/1ps
module pov_ov_config_bench;
  localparam logic [23:0] FLT = 24'h7FF01;
  localparam logic [23:0] OK  = 24'h7FF00;
  // Block ports, counters and the reference copy of the registers.
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  cmd_code;
  logic [15:0] cmd_wr_data, rd_data_ff, loop_scale_ff, monitor_scale_ff;
  logic        cmd_wr_stb, cmd_rd_stb, rd_valid_ff, cmd_nack_ff;
  logic        conv_enable_ff, out_enable_ff, ov_fault_ff, ov_lockout_ff;
  logic [2:0]  vin_exponent = 3'h0;
  logic [2:0]  vout_exponent = 3'h0;
  logic [23:0] vin_meas = 24'h0;
  logic [23:0] vout_meas = 24'h0;
  int          bad_count = 0;
  int          checks = 0;
  int          seed = 15165;
  int          n;
  logic [15:0] mdl [int];
  logic [7:0]  codes [6] = '{8'h29, 8'h2A, 8'h35, 8'h36, 8'h40, 8'h41};

  // Clock at 125 MHz.
  always #4 sys_clk = ~sys_clk;

  // Block with short delay counts except the longest restart interval, and its host.
  pov_ov_config #(.DLY1_0(20), .DLY1_1(30), .DLY1_2(40), .DLY2_0(50),
    .DLY2_1(60)) DUT (.sys_clk, .rst_n, .cmd_code,
    .cmd_wr_stb, .cmd_wr_data, .cmd_rd_stb, .rd_data_ff, .rd_valid_ff,
    .cmd_nack_ff, .vin_exponent, .vout_exponent, .vin_meas, .vout_meas,
    .loop_scale_ff, .monitor_scale_ff, .conv_enable_ff, .out_enable_ff,
    .ov_fault_ff, .ov_lockout_ff);
  pov_host_model host (.sys_clk, .cmd_code, .cmd_wr_stb, .cmd_rd_stb,
    .cmd_wr_data, .rd_data_ff, .rd_valid_ff, .cmd_nack_ff);

  // Counts one comparison and reports a mismatch.
  task automatic check(input logic [15:0] seen, want, input string what);
    checks++;
    if (seen !== want) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : conclude

  function automatic logic [15:0] exp_rd(input logic [7:0] c);
    logic [15:0] m;
    m = mdl.exists(c) ? mdl[c] : 16'h0;
    case (c)
      8'h29: return m & 16'hFBFF;
      8'h2A: return m & 16'h3BFF;
      8'h35, 8'h36: return {{2{vin_exponent[2]}}, vin_exponent, m[10:0]};
      8'h40: return {{2{vout_exponent[2]}}, vout_exponent, m[10:0]};
      8'h41: return {8'h0, m[7:0]};
      default: return 16'h0;
    endcase
  endfunction : exp_rd

  // One host access, checked against the reference copy.
  task automatic acc(input logic [7:0] c, input logic [15:0] d, input logic w);
    logic [17:0] r;
    logic        hit;
    hit = mdl.exists(c);
    host.xfer(c, d, w, r);
    if (w && hit) mdl[c] = d;
    check(16'(r[17:16]), 16'({!w, !hit}), "flags");
    if (!w) check(r[15:0], exp_rd(c), "data");
  endtask : acc

  // Drives both voltages, then checks the two detector outputs.
  task automatic step(input logic [23:0] vi, vo, input logic ce, f);
    @(negedge sys_clk);
    vin_meas = vi;
    vout_meas = vo;
    repeat (2) @(negedge sys_clk);
    check(16'({conv_enable_ff, ov_fault_ff}), 16'({ce, f}), "det");
  endtask : step

  // Waits a bounded time for the output enable to reach lvl.
  task automatic wait_out(input logic lvl, input int lim);
    n = 0;
    checks++;
    while (out_enable_ff !== lvl) begin
      @(negedge sys_clk);
      n++;
      if (n > lim) begin
        check(16'(out_enable_ff), 16'(lvl), "out_enable");
        conclude();
      end
    end
  endtask : wait_out

  // Resets the block with no fault present and reloads the reference copy.
  task automatic do_reset;
    @(negedge sys_clk);
    rst_n = 1'b0;
    vin_meas = 24'h0;
    vout_meas = OK;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    foreach (codes[i]) mdl[codes[i]] = 16'h0;
    mdl[8'h40] = 16'(pov_pkg::RST_OV_LIMIT);
    mdl[8'h41] = 16'(pov_pkg::RST_OV_RESP);
    check(16'({out_enable_ff, ov_lockout_ff}), 16'h2, "rst");
    // A nonzero turn-on level keeps a zero input from toggling conversion.
    acc(8'h35, 16'h0064, 1'b1);
  endtask : do_reset

  // Register access, thresholds, then every fault response.
  initial begin
    do_reset();
    repeat (4) begin
      vin_exponent = 3'($random(seed));
      vout_exponent = 3'($random(seed));
      foreach (codes[i]) acc(codes[i], 16'h0, 1'b0);
      foreach (codes[i]) acc(codes[i], 16'($random(seed)), 1'b1);
      check(loop_scale_ff, exp_rd(8'h29), "loop");
      check(monitor_scale_ff, exp_rd(8'h2A), "mon");
    end
    acc(8'h42, 16'hFFFF, 1'b1);
    acc(8'h42, 16'h0, 1'b0);
    $display("register access done");
    vin_exponent = 3'h1;
    vout_exponent = 3'h0;
    acc(8'h41, 16'h0, 1'b1);
    acc(8'h35, 16'hF864, 1'b1);
    acc(8'h36, 16'h0032, 1'b1);
    acc(8'h40, 16'h00C8, 1'b1);
    step(24'h0, 24'hC800, 1'b0, 1'b0);
    step(24'hC7FF, 24'hC800, 1'b0, 1'b0);
    step(24'hC800, 24'hC801, 1'b1, 1'b1);
    step(24'h6401, 24'hC800, 1'b1, 1'b0);
    step(24'h6400, 24'hC800, 1'b0, 1'b0);
    $display("thresholds done");
    do_reset();
    acc(8'h41, 16'h0, 1'b1);
    step(24'h0, FLT, 1'b0, 1'b1);
    repeat (60) @(negedge sys_clk);
    check(16'(out_enable_ff), 16'h1, "ignore");
    acc(8'h41, 16'h00C0, 1'b1);
    wait_out(1'b0, 8);
    repeat (60) @(negedge sys_clk);
    check(16'(out_enable_ff), 16'h0, "hold");
    step(24'h0, OK, 1'b0, 1'b0);
    wait_out(1'b1, 8);
    acc(8'h41, 16'h0088, 1'b1);
    step(24'h0, FLT, 1'b0, 1'b1);
    wait_out(1'b0, 8);
    wait_out(1'b1, 80);
    check(16'(n >= 48 && n <= 60), 16'h1, "gap");
    wait_out(1'b0, 8);
    repeat (100) @(negedge sys_clk);
    check(16'({out_enable_ff, ov_lockout_ff}), 16'h1, "lockout");
    do_reset();
    acc(8'h41, 16'h00B8, 1'b1);
    step(24'h0, FLT, 1'b0, 1'b1);
    repeat (400) @(negedge sys_clk);
    check(16'(ov_lockout_ff), 16'h0, "endless");
    step(24'h0, OK, 1'b0, 1'b0);
    wait_out(1'b1, 80);
    acc(8'h41, 16'h0040, 1'b1);
    step(24'h0, FLT, 1'b0, 1'b1);
    step(24'h0, OK, 1'b0, 1'b0);
    repeat (40) @(negedge sys_clk);
    check(16'({out_enable_ff, ov_lockout_ff}), 16'h2, "short");
    for (int k = 0; k < 3; k++) begin
      do_reset();
      acc(8'h41, 16'(8'h40 + k), 1'b1);
      step(24'h0, FLT, 1'b0, 1'b1);
      wait_out(1'b0, 60);
      check(16'(n >= 16 + 10 * k && n <= 26 + 10 * k), 16'h1, "ride");
      repeat (8) @(negedge sys_clk);
      check(16'(ov_lockout_ff), 16'h1, "ride lock");
    end
    $display("fault responses done");
    conclude();
  end
endmodule : pov_ov_config_bench
